/* File: dv/cdpp_sensor.sv */
`timescale 1ns/10ps
module cdpp_sensor (
  // Link pins toward the block
  output logic pclk,
  output logic fsync,
  output logic lsync,
  output logic [19:0] dat,
  // Bench control
  input wire logic run
);
  ////////////////////////////////////////////////////////////
  // Pixel clock, parked low between frames
  initial
  begin
    pclk = 1'b0;
    // Offset so its edges never line up with the system clock
    #3.3;
    forever #7.5 pclk = run ? ~pclk : 1'b0;
  end
  // Pins idle at time zero
  initial
  begin
    fsync = 1'b0;
    lsync = 1'b0;
    dat = 20'h0_0000;
  end
  ////////////////////////////////////////////////////////////
  // One clock of pins, driven on the rise and taken at the next rise
  task automatic put(input logic [19:0] w, input logic f, input logic l);
    @(posedge pclk);
    dat <= w;
    fsync <= f;
    lsync <= l;
  endtask
endmodule

/* File: dv/cdpp_top_test.sv */
`timescale 1ns/10ps
module cdpp_top_test;
  // Clock, reset and display side
  logic sys_clk;
  logic reset_n;
  logic sys_clk_en;
  logic disp_ready;
  cdpp_pkg::cdpp_cam_mode_t cam_mode;
  cdpp_pkg::cdpp_fmt_t disp_format;
  // Link pins from the sensor model
  logic run;
  logic pclk;
  logic fs;
  logic ls;
  logic [19:0] sdat;
  // Display outputs
  logic [23:0] dbus;
  logic dval;
  logic dfs;
  logic dls;
  logic ovf;
  // Expected beats as {frame, line, bus}
  logic [25:0] exp_q[$];
  logic rnd;
  logic ovph;
  int beats;
  int n_mismatch;
  int n_checks;
  ////////////////////////////////////////////////////////////
  cdpp_top u_cdpp_top (.sys_clk(sys_clk), .reset_n(reset_n), .sys_clk_en(sys_clk_en), .cam_mode(cam_mode),
    .disp_format(disp_format), .sensor_pixel_clock(pclk), .sensor_frame_sync(fs), .sensor_line_sync(ls),
    .sensor_data_bus(sdat), .display_data_bus(dbus), .disp_valid(dval), .disp_ready(disp_ready),
    .disp_frame_start(dfs), .disp_line_start(dls), .cam_overflow(ovf));
  cdpp_sensor u_cdpp_sensor (.pclk(pclk), .fsync(fs), .lsync(ls), .dat(sdat), .run(run));
  ////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input string what, input logic [25:0] seen, input logic [25:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Reference placement of a source word on the display lines
  function automatic logic [23:0] map(input cdpp_pkg::cdpp_fmt_t f, input logic [23:0] w, input bit y);
    case (f)
      cdpp_pkg::FMT_RGB16: return {8'h00, w[20:16], w[13:8], w[4:0]};
      cdpp_pkg::FMT_RGB18: return {6'h00, w[21:16], w[13:8], w[5:0]};
      cdpp_pkg::FMT_RGB24: return {2'h0, w[21:16], w[15:0]};
      cdpp_pkg::FMT_YC8: return {16'h0000, y ? w[17:10] : w[7:0]};
      cdpp_pkg::FMT_YC16: return {8'h00, w[17:10], w[7:0]};
      cdpp_pkg::FMT_YC20: return {4'h0, w[19:0]};
      default: return {8'h00, w[15:0]};
    endcase
  endfunction
  // Queue the beats one captured word should give
  task automatic expw(input logic [23:0] w, input bit f, input bit l);
    exp_q.push_back({f, l, map(disp_format, w, 1'b0)});
    if (disp_format == cdpp_pkg::FMT_YC8)
      exp_q.push_back({2'b00, map(disp_format, w, 1'b1)});
  endtask
  ////////////////////////////////////////////////////////////
  // Embedded traffic, sync pins toggled at random since they carry nothing
  task automatic ep(input logic [19:0] w);
    u_cdpp_sensor.put(w, 1'($urandom), 1'($urandom));
  endtask
  task automatic code(input logic [9:0] xy);
    logic [9:0] s[4];
    s = '{10'h3FF, 10'h000, 10'h000, xy};
    foreach (s[i]) ep({s[i], s[i]});
  endtask
  // One active line; a new frame is flagged by a V=1 code before it
  task automatic eline(input bit dual, input bit nf);
    logic [9:0] c;
    logic [9:0] y;
    code(nf ? 10'h2C0 : 10'h240);
    repeat (6) ep(20'h4_0100);
    code(10'h200);
    for (int i = 0; i < 6; i++)
    begin
      c = 10'h100 + 10'($urandom_range(511));
      y = 10'h100 + 10'($urandom_range(511));
      if (dual)
        ep({y, c});
      else
      begin
        ep({10'h000, c});
        ep({10'h000, y});
      end
      expw({4'h0, y, c}, nf && i == 0, i == 0);
    end
    // Lone chroma at line end has no partner and must vanish
    if (!dual)
      ep({10'h000, 10'h155});
    code(10'h240);
    repeat (24) ep(20'h4_0100);
    // Quiet syncs last: a following gated run must not see a stale line sync
    u_cdpp_sensor.put(20'h4_0100, 1'b0, 1'b0);
  endtask
  // Gated line: frame pulse on a new frame, then data only while line sync is high
  task automatic gline(input bit nf);
    logic [19:0] w;
    if (nf)
      u_cdpp_sensor.put(20'($urandom), 1'b1, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      w = 20'($urandom);
      u_cdpp_sensor.put(w, 1'b0, 1'b1);
      expw({4'h0, w}, nf && i == 0, i == 0);
    end
    // Idle long enough that a two-beat format drains before the next line
    repeat (30) u_cdpp_sensor.put(20'($urandom), 1'b0, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  // System clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Random stall and enable pattern on the display side
  always @(posedge sys_clk)
    if (rnd)
    begin
      disp_ready <= ($urandom % 4) != 0;
      sys_clk_en <= ($urandom % 8) != 0;
    end
  // Every accepted beat outside the overflow phase is compared with the model
  always @(posedge sys_clk)
    if (reset_n && sys_clk_en && disp_ready && dval)
    begin
      beats++;
      if (!ovph && exp_q.size() == 0)
        check("extra beat", 26'h000_0001, 26'h000_0000);
      else if (!ovph)
        check("beat", {dfs, dls, dbus}, exp_q.pop_front());
    end
  // Watchdog, far beyond the expected run of about 50 us
  initial
  begin
    #1000000;
    n_mismatch++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    sys_clk_en = 1'b0;
    disp_ready = 1'b0;
    cam_mode = cdpp_pkg::CAM_EMB_SINGLE;
    disp_format = cdpp_pkg::FMT_RGB16;
    run = 1'b1;
    rnd = 1'b0;
    ovph = 1'b0;
    beats = 0;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(32'h9995_9627));
    repeat (6) @(posedge sys_clk);
    check("reset", {22'h00_0000, dval, dfs, dls, ovf}, 26'h000_0000);
    reset_n <= 1'b1;
    rnd <= 1'b1;
    // Every capture mode against every display format
    for (int m = 0; m < 3; m++)
      for (int f = 0; f < 7; f++)
      begin
        @(posedge sys_clk);
        cam_mode <= cdpp_pkg::cdpp_cam_mode_t'(m);
        disp_format <= cdpp_pkg::cdpp_fmt_t'(f);
        run = 1'b1;
        repeat (4) @(posedge pclk);
        for (int l = 0; l < 3; l++)
          if (m == 2)
            gline(l == 0);
          else
            eline(m == 1, l == 0);
        run = 1'b0;
        for (int t = 0; t < 300 && exp_q.size() != 0; t++)
          @(posedge sys_clk);
        check("drained", 26'(exp_q.size()), 26'h000_0000);
      end
    check("no overflow", {25'h000_0000, ovf}, 26'h000_0001 ^ 26'h000_0001);
    // Stalled display: buffer fills and the excess is dropped
    ovph = 1'b1;
    rnd <= 1'b0;
    @(posedge sys_clk);
    disp_ready <= 1'b0;
    sys_clk_en <= 1'b1;
    run = 1'b1;
    repeat (20) u_cdpp_sensor.put(20'($urandom), 1'b0, 1'b1);
    u_cdpp_sensor.put(20'h0_0000, 1'b0, 1'b0);
    run = 1'b0;
    repeat (10) @(posedge sys_clk);
    check("overflow", {25'h000_0000, ovf}, 26'h000_0001);
    beats = 0;
    disp_ready <= 1'b1;
    repeat (40) @(posedge sys_clk);
    check("kept", 26'(beats >= cdpp_pkg::FIFO_DEPTH), 26'h000_0001);
    report_and_stop();
  end
endmodule

/* File: hw/cdpp_fifo.sv */
`timescale 1ns/10ps
module cdpp_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  // Write side, link clock
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  // Read side, system clock
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  input wire logic rd_en,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input wire logic rd_ready
);

  localparam int AW = $clog2(DEPTH);

  // Write domain state, memory included
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wbin;
    logic [AW:0] wgray;
    logic [AW:0] rg_s1;
    logic [AW:0] rg_s2;
  } cdpp_fw_t;

  // Read domain state, output word registered
  typedef struct packed {
    logic [AW:0] rbin;
    logic [AW:0] rgray;
    logic [AW:0] wg_s1;
    logic [AW:0] wg_s2;
    logic valid;
    logic [WIDTH-1:0] data;
  } cdpp_fr_t;

  cdpp_fw_t w_r, w_nxt;
  cdpp_fr_t r_r, r_nxt;
  logic [AW:0] wb_inc;
  logic [AW:0] rb_inc;
  logic empty;

  ////////////////////////////////////////////////////////////////////////////
  // Full when the write gray pointer laps the synced read pointer
  assign wr_ready = w_r.wgray != {~w_r.rg_s2[AW:AW-1], w_r.rg_s2[AW-2:0]};
  assign wb_inc = w_r.wbin + (AW+1)'(1);

  // Write process
  always_comb
  begin
    w_nxt = w_r;
    w_nxt.rg_s1 = r_r.rgray;
    w_nxt.rg_s2 = w_r.rg_s1;
    if (wr_valid && wr_ready)
    begin
      w_nxt.mem[w_r.wbin[AW-1:0]] = wr_data;
      w_nxt.wbin = wb_inc;
      w_nxt.wgray = wb_inc ^ (wb_inc >> 1);
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n)
  begin
    if (!wr_rst_n)
      w_r <= '0;
    else
      w_r <= w_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Empty when read gray pointer meets synced write pointer
  assign empty = r_r.rgray == r_r.wg_s2;
  assign rb_inc = r_r.rbin + (AW+1)'(1);
  assign rd_valid = r_r.valid;
  assign rd_data = r_r.data;

  // Read process, frozen while the enable is low
  always_comb
  begin
    r_nxt = r_r;
    if (rd_en)
    begin
      r_nxt.wg_s1 = w_r.wgray;
      r_nxt.wg_s2 = r_r.wg_s1;
      if (!r_r.valid || rd_ready)
      begin
        r_nxt.valid = !empty;
        if (!empty)
        begin
          r_nxt.data = w_r.mem[r_r.rbin[AW-1:0]];
          r_nxt.rbin = rb_inc;
          r_nxt.rgray = rb_inc ^ (rb_inc >> 1);
        end
      end
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n)
  begin
    if (!rd_rst_n)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

endmodule

/* File: hw/cdpp_pkg.sv */
package cdpp_pkg;

  // Bus widths
  localparam int SENS_W = 20;
  localparam int CMP_W = 10;
  localparam int DISP_W = 24;
  localparam int WORD_W = 26;
  localparam int FIFO_DEPTH = 8;

  // Source word layout: flags above 24 data bits
  localparam int FLAG_FRAME = 25;
  localparam int FLAG_LINE = 24;
  localparam int Y_LSB = 10;

  // Embedded code bytes, compared on the upper eight bits of a component
  localparam logic [7:0] CODE_ONES = 8'hFF;
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam int STAT_V = 7;
  localparam int STAT_H = 6;

  // Camera capture modes
  typedef enum logic [1:0] {CAM_EMB_SINGLE, CAM_EMB_DUAL, CAM_GATED} cdpp_cam_mode_t;

  // Display pixel formats
  typedef enum logic [2:0] {FMT_RGB16, FMT_RGB18, FMT_RGB24, FMT_YC8, FMT_YC16, FMT_YC20,
                            FMT_SMART} cdpp_fmt_t;

  // One bit group: source LSB, bus LSB, length
  typedef struct packed {
    logic [4:0] src;
    logic [4:0] dst;
    logic [4:0] len;
  } cdpp_grp_t;

  function automatic cdpp_grp_t cdpp_grp(input int s, input int d, input int l);
    return '{src: 5'(s), dst: 5'(d), len: 5'(l)};
  endfunction

  // Group placement per format, indexed by format then group
  localparam cdpp_grp_t MAP_TBL [7][3] = '{
    '{cdpp_grp(0, 0, 5), cdpp_grp(8, 5, 6), cdpp_grp(16, 11, 5)},
    '{cdpp_grp(0, 0, 6), cdpp_grp(8, 6, 6), cdpp_grp(16, 12, 6)},
    '{cdpp_grp(0, 0, 8), cdpp_grp(8, 8, 8), cdpp_grp(16, 16, 6)},
    '{cdpp_grp(0, 0, 8), cdpp_grp(0, 0, 0), cdpp_grp(0, 0, 0)},
    '{cdpp_grp(0, 0, 8), cdpp_grp(10, 8, 8), cdpp_grp(0, 0, 0)},
    '{cdpp_grp(0, 0, 10), cdpp_grp(10, 10, 10), cdpp_grp(0, 0, 0)},
    '{cdpp_grp(0, 0, 16), cdpp_grp(0, 0, 0), cdpp_grp(0, 0, 0)}
  };

endpackage

/* File: hw/cdpp_top.sv */
`timescale 1ns/10ps
module cdpp_top (
  // System clock and control
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic sys_clk_en,
  // Configuration, system domain
  input wire cdpp_pkg::cdpp_cam_mode_t cam_mode,
  input wire cdpp_pkg::cdpp_fmt_t disp_format,
  // Sensor link
  input wire logic sensor_pixel_clock,
  input wire logic sensor_frame_sync,
  input wire logic sensor_line_sync,
  input wire logic [cdpp_pkg::SENS_W-1:0] sensor_data_bus,
  // Display stream
  output logic [cdpp_pkg::DISP_W-1:0] display_data_bus,
  output logic disp_valid,
  input wire logic disp_ready,
  output logic disp_frame_start,
  output logic disp_line_start,
  // Status
  output logic cam_overflow
);

  ////////////////////////////////////////////////////////////////////////////
  // Types

  // Embedded code decoder position
  typedef enum logic [1:0] {D_IDLE, D_ONE, D_ZERO1, D_ZERO2} cdpp_dec_t;

  // Link domain state
  typedef struct packed {
    cdpp_pkg::cdpp_cam_mode_t mode_s1;
    cdpp_pkg::cdpp_cam_mode_t mode_s2;
    logic [cdpp_pkg::SENS_W-1:0] data_q;
    logic fsync_q;
    logic fsync_d;
    logic lsync_q;
    logic lsync_d;
    cdpp_dec_t dec;
    logic active;
    logic vblank;
    logic frame_pend;
    logic line_pend;
    logic half;
    logic [cdpp_pkg::CMP_W-1:0] c_hold;
    logic push;
    logic [cdpp_pkg::WORD_W-1:0] word;
    logic ovf;
  } cdpp_pix_t;

  // System domain state
  typedef struct packed {
    logic ovf_s1;
    logic ovf_s2;
    logic valid;
    logic second;
    logic ybeat;
    logic fs;
    logic ls;
    logic [cdpp_pkg::WORD_W-1:0] word;
    logic [cdpp_pkg::DISP_W-1:0] bus;
  } cdpp_sys_t;

  cdpp_pix_t p_r, p_nxt;
  cdpp_sys_t s_r, s_nxt;

  // Buffer handshake
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [cdpp_pkg::WORD_W-1:0] fifo_rd_data;

  // Decoder helpers
  logic emb;
  logic [cdpp_pkg::CMP_W-1:0] ycomp;
  logic [cdpp_pkg::CMP_W-1:0] ccomp;
  logic [7:0] ytop;
  logic take;
  logic load;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Reserved code values never carry picture data
  function automatic logic is_code(input logic [cdpp_pkg::CMP_W-1:0] c);
    return c[9:2] == cdpp_pkg::CODE_ONES || c[9:2] == cdpp_pkg::CODE_ZERO;
  endfunction

  // Place up to three bit groups on the display bus
  function automatic logic [cdpp_pkg::DISP_W-1:0] map_pixel(
    input cdpp_pkg::cdpp_fmt_t fmt,
    input logic [cdpp_pkg::DISP_W-1:0] src);
    logic [cdpp_pkg::DISP_W-1:0] o;
    cdpp_pkg::cdpp_grp_t g;
    o = '0;
    for (int k = 0; k < 3; k++)
    begin
      g = cdpp_pkg::MAP_TBL[fmt][k];
      // Each group contiguous, LSB to LSB
      for (int b = 0; b < cdpp_pkg::DISP_W; b++)
      begin
        if (b < int'(g.len) && b + int'(g.dst) < cdpp_pkg::DISP_W &&
            b + int'(g.src) < cdpp_pkg::DISP_W)
          o[b + int'(g.dst)] = src[b + int'(g.src)];
      end
    end
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link side: capture and code decode on the sensor pixel clock

  // Embedded modes share the decoder
  assign emb = p_r.mode_s2 != cdpp_pkg::CAM_GATED;
  // Dual format carries luma in the upper half
  assign ycomp = (p_r.mode_s2 == cdpp_pkg::CAM_EMB_DUAL) ? p_r.data_q[19:10] : p_r.data_q[9:0];
  assign ccomp = p_r.data_q[9:0];
  assign ytop = ycomp[9:2];

  // Link domain next state
  always_comb
  begin
    logic do_push;
    logic [cdpp_pkg::DISP_W-1:0] pdata;
    do_push = 1'b0;
    pdata = '0;
    p_nxt = p_r;
    // Mode comes from the system domain: two flops
    p_nxt.mode_s1 = cam_mode;
    p_nxt.mode_s2 = p_r.mode_s1;
    // Pins are synchronous to this clock, one register stage
    p_nxt.data_q = sensor_data_bus;
    p_nxt.fsync_q = sensor_frame_sync;
    p_nxt.lsync_q = sensor_line_sync;
    p_nxt.fsync_d = p_r.fsync_q;
    p_nxt.lsync_d = p_r.lsync_q;
    p_nxt.push = 1'b0;
    // A word offered while the buffer is full is lost
    if (p_r.push && !fifo_wr_ready)
      p_nxt.ovf = 1'b1;
    if (emb)
    begin
      // Sync pins ignored; timing only from data
      case (p_r.dec)
        D_IDLE:
        begin
          if (ytop == cdpp_pkg::CODE_ONES)
            p_nxt.dec = D_ONE;
        end
        D_ONE:
        begin
          if (ytop == cdpp_pkg::CODE_ZERO)
            p_nxt.dec = D_ZERO1;
          else if (ytop != cdpp_pkg::CODE_ONES)
            p_nxt.dec = D_IDLE;
        end
        D_ZERO1:
        begin
          // Preamble is ones, zero, zero
          if (ytop == cdpp_pkg::CODE_ZERO)
            p_nxt.dec = D_ZERO2;
          else if (ytop == cdpp_pkg::CODE_ONES)
            p_nxt.dec = D_ONE;
          else
            p_nxt.dec = D_IDLE;
        end
        D_ZERO2:
        begin
          // Status word: blanking flags give line and frame
          p_nxt.dec = D_IDLE;
          p_nxt.vblank = ycomp[cdpp_pkg::STAT_V];
          p_nxt.half = 1'b0;
          if (ycomp[cdpp_pkg::STAT_H])
            p_nxt.active = 1'b0;
          else
          begin
            p_nxt.active = !ycomp[cdpp_pkg::STAT_V];
            if (!ycomp[cdpp_pkg::STAT_V])
            begin
              p_nxt.line_pend = 1'b1;
              // First active line after vertical blanking
              if (p_r.vblank)
                p_nxt.frame_pend = 1'b1;
            end
          end
        end
        default:
          p_nxt.dec = D_IDLE;
      endcase
      // Only words inside an active line, codes filtered out
      if (p_r.dec == D_IDLE && p_r.active && !is_code(ycomp))
      begin
        if (p_r.mode_s2 == cdpp_pkg::CAM_EMB_DUAL)
        begin
          // Two components arrive together
          if (!is_code(ccomp))
          begin
            do_push = 1'b1;
            pdata = {4'h0, p_r.data_q};
          end
        end
        else if (!p_r.half)
        begin
          // One component a clock: hold chroma, pair with luma
          p_nxt.c_hold = ycomp;
          p_nxt.half = 1'b1;
        end
        else
        begin
          do_push = 1'b1;
          p_nxt.half = 1'b0;
          pdata = {4'h0, ycomp, p_r.c_hold};
        end
      end
    end
    else
    begin
      // Gated: frame sync edge opens a frame
      p_nxt.dec = D_IDLE;
      p_nxt.active = 1'b0;
      if (p_r.fsync_q && !p_r.fsync_d)
        p_nxt.frame_pend = 1'b1;
      if (p_r.lsync_q && !p_r.lsync_d)
        p_nxt.line_pend = 1'b1;
      // Data taken only while line sync is high
      if (p_r.lsync_q)
      begin
        do_push = 1'b1;
        pdata = {4'h0, p_r.data_q};
        p_nxt.line_pend = 1'b0;
        p_nxt.frame_pend = 1'b0;
        p_nxt.word[cdpp_pkg::FLAG_LINE] = !p_r.lsync_d;
        p_nxt.word[cdpp_pkg::FLAG_FRAME] = p_r.frame_pend ||
                                           (p_r.fsync_q && !p_r.fsync_d);
      end
    end
    // Word with regenerated sync flags
    if (do_push)
    begin
      p_nxt.push = 1'b1;
      p_nxt.word[cdpp_pkg::DISP_W-1:0] = pdata;
      if (emb)
      begin
        p_nxt.word[cdpp_pkg::FLAG_FRAME] = p_r.frame_pend;
        p_nxt.word[cdpp_pkg::FLAG_LINE] = p_r.line_pend;
        p_nxt.frame_pend = 1'b0;
        p_nxt.line_pend = 1'b0;
      end
    end
  end

  // Link domain register
  always_ff @(posedge sensor_pixel_clock or negedge reset_n)
  begin
    if (!reset_n)
      p_r <= '0;
    else
      p_r <= p_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock crossing buffer; the sensor cannot be stalled, so full drops

  cdpp_fifo #(
    .WIDTH(cdpp_pkg::WORD_W),
    .DEPTH(cdpp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .wr_clk(sensor_pixel_clock),
    .wr_rst_n(reset_n),
    .wr_valid(p_r.push),
    .wr_data(p_r.word),
    .wr_ready(fifo_wr_ready),
    .rd_clk(sys_clk),
    .rd_rst_n(reset_n),
    .rd_en(sys_clk_en),
    .rd_valid(fifo_rd_valid),
    .rd_data(fifo_rd_data),
    .rd_ready(fifo_rd_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Display side on the system clock

  // Output slot free this cycle
  assign take = !s_r.valid || disp_ready;
  // Pending luma beat blocks the next pop
  assign fifo_rd_ready = take && !s_r.second;
  assign load = sys_clk_en && fifo_rd_ready && fifo_rd_valid;

  // System domain next state
  always_comb
  begin
    s_nxt = s_r;
    if (sys_clk_en)
    begin
      // Overflow level crosses through two flops
      s_nxt.ovf_s1 = p_r.ovf;
      s_nxt.ovf_s2 = s_r.ovf_s1;
      if (take)
      begin
        if (s_r.second)
        begin
          // Luma follows chroma on the same lines
          s_nxt.bus = map_pixel(cdpp_pkg::FMT_YC8, s_r.word[cdpp_pkg::DISP_W-1:0] >> cdpp_pkg::Y_LSB);
          s_nxt.second = 1'b0;
          s_nxt.ybeat = 1'b1;
          s_nxt.fs = 1'b0;
          s_nxt.ls = 1'b0;
          s_nxt.valid = 1'b1;
        end
        else if (fifo_rd_valid)
        begin
          // Fresh word, mapped per format
          s_nxt.word = fifo_rd_data;
          s_nxt.bus = map_pixel(disp_format, fifo_rd_data[cdpp_pkg::DISP_W-1:0]);
          s_nxt.second = disp_format == cdpp_pkg::FMT_YC8;
          s_nxt.ybeat = 1'b0;
          s_nxt.fs = fifo_rd_data[cdpp_pkg::FLAG_FRAME];
          s_nxt.ls = fifo_rd_data[cdpp_pkg::FLAG_LINE];
          s_nxt.valid = 1'b1;
        end
        else
          s_nxt.valid = 1'b0;
      end
    end
  end

  // System domain register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Outputs straight from registers
  assign display_data_bus = s_r.bus;
  assign disp_valid = s_r.valid;
  assign disp_frame_start = s_r.fs;
  assign disp_line_start = s_r.ls;
  assign cam_overflow = s_r.ovf_s2;

  ////////////////////////////////////////////////////////////////////////////
  // Checks, link domain

  // Three-word preamble then a start-of-line status
  sequence s_preamble;
    emb && p_r.dec != D_ZERO2 && ytop == cdpp_pkg::CODE_ONES ##1
    emb && ytop == cdpp_pkg::CODE_ZERO ##1 emb && ytop == cdpp_pkg::CODE_ZERO;
  endsequence

  sequence s_sav_status;
    emb && !ycomp[cdpp_pkg::STAT_H] && !ycomp[cdpp_pkg::STAT_V];
  endsequence

  a_sav_opens_line: assert property (
    @(posedge sensor_pixel_clock) disable iff (!reset_n)
    s_preamble ##1 s_sav_status |=> p_r.active && p_r.line_pend)
    else $error("start code did not open a line");

  a_blank_not_pushed: assert property (
    @(posedge sensor_pixel_clock) disable iff (!reset_n)
    emb && !p_r.active |=> !p_r.push)
    else $error("blanking word pushed");

  a_codes_stripped: assert property (
    @(posedge sensor_pixel_clock) disable iff (!reset_n)
    p_r.push && $past(emb) |-> !is_code(p_r.word[9:0]) && !is_code(p_r.word[19:10]))
    else $error("timing code reached the pixel stream");

  a_gated_line_take: assert property (
    @(posedge sensor_pixel_clock) disable iff (!reset_n)
    !emb && p_r.lsync_q |=> p_r.push && p_r.word[19:0] == $past(p_r.data_q))
    else $error("gated word not captured");

  a_gated_idle: assert property (
    @(posedge sensor_pixel_clock) disable iff (!reset_n)
    !emb && !p_r.lsync_q |=> !p_r.push)
    else $error("capture outside line sync");

  ////////////////////////////////////////////////////////////////////////////
  // Checks, display domain

  a_rgb16_map: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    load && disp_format == cdpp_pkg::FMT_RGB16 |=> display_data_bus[15:0] ==
      {s_r.word[20:16], s_r.word[13:8], s_r.word[4:0]} && display_data_bus[23:16] == 8'h00)
    else $error("rgb16 placement wrong");

  a_rgb18_map: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    load && disp_format == cdpp_pkg::FMT_RGB18 |=> display_data_bus[17:0] ==
      {s_r.word[21:16], s_r.word[13:8], s_r.word[5:0]})
    else $error("rgb18 placement wrong");

  a_rgb24_map: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    load && disp_format == cdpp_pkg::FMT_RGB24 |=> display_data_bus[21:0] ==
      {s_r.word[21:16], s_r.word[15:0]})
    else $error("rgb24 placement wrong");

  a_yc8_beats: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    load && disp_format == cdpp_pkg::FMT_YC8 |=> display_data_bus == {16'h0000, s_r.word[7:0]}
      && s_r.second)
    else $error("ycrcb8 chroma beat wrong");

  a_yc8_luma: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    sys_clk_en && take && s_r.second |=> display_data_bus == {16'h0000, s_r.word[17:10]})
    else $error("ycrcb8 luma beat wrong");

  a_yc16_map: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    load && disp_format == cdpp_pkg::FMT_YC16 |=> display_data_bus[15:0] ==
      {s_r.word[17:10], s_r.word[7:0]})
    else $error("ycrcb16 placement wrong");

  a_yc20_map: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    load && disp_format == cdpp_pkg::FMT_YC20 |=> display_data_bus[19:0] == s_r.word[19:0])
    else $error("ycrcb20 placement wrong");

  a_smart_pass: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    load && disp_format == cdpp_pkg::FMT_SMART |=> display_data_bus == {8'h00, s_r.word[15:0]})
    else $error("smart word altered");

  a_stall_holds: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    disp_valid && !disp_ready |=> disp_valid && $stable(display_data_bus))
    else $error("output changed under stall");

endmodule
